// file: sfr_core.sv
/*
 * Serial flash slice: null, reset arm/execute, unique-ID read and
 * parameter-table read, plus the event FIFO that feeds the interpreter.
 * Assumes a host driving cs_n_i, sclk_i and si_i; sclk_i may stop when
 * cs_n_i is high. Data on so_o changes after a rising sclk_i edge.
 */
`include "sfr_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Event FIFO
// ----------------------------------------
module sfr_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire logic empty = (wr_ptr == rd_ptr);
    wire logic push = in_valid_i & ~full;
    wire logic pop = out_valid_o & out_ready_i;

    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule : sfr_fifo

// ----------------------------------------
// Command slice top
// ----------------------------------------
module sfr_core
    import sfr_pkg::*;
#(
    // Arbitrary value; each part carries its own
    parameter logic [127:0] UNIQUE_ID = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic prog_busy_i,
    output logic soft_reset_o,
    output logic abort_o,
    output logic standby_o,
    output logic busy_o,
    output logic overrun_o
);
    localparam logic [10:0] REC_LAST = 11'(`SFR_REC_CYC - 1);

    function automatic logic [7:0] sfr_tbl(input logic [23:0] a);
        case (a)
            24'h000000: sfr_tbl = `SFR_TBL_B0;
            24'h000001: sfr_tbl = `SFR_TBL_B1;
            24'h000002: sfr_tbl = `SFR_TBL_B2;
            24'h000003: sfr_tbl = `SFR_TBL_B3;
            default: sfr_tbl = `SFR_TBL_FILL;
        endcase
    endfunction : sfr_tbl

    // ----------------------------------------
    // Link domain
    // ----------------------------------------
    logic [15:0] cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [23:0] addr;
    logic op_tog;
    logic [7:0] op_hold;
    logic [2:0] ign_s;
    logic ign_q;
    logic ign_src;

    // Frame logic is cleared by deselect, since sclk_i may be idle then
    wire logic link_clr = cs_n_i | ~reset_n_i;
    wire logic [15:0] next_cnt = (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
    wire logic [7:0] next_sh = {sh[6:0], si_i};
    wire logic [15:0] k = next_cnt - `SFR_HDR_BITS;
    wire logic hdr_done = next_cnt >= `SFR_HDR_BITS;
    wire logic uid_act = (op == `SFR_OP_UID);
    wire logic tbl_act = (op == `SFR_OP_TBL);
    wire logic uid_bit = UNIQUE_ID[~k[6:0]];
    wire logic [7:0] tbl_byte = sfr_tbl(addr + {11'h000, k[15:3]});
    wire logic tbl_bit = tbl_byte[~k[2:0]];
    wire logic next_oe = hdr_done & (uid_act | tbl_act);
    wire logic next_so = next_oe & (uid_act ? uid_bit : tbl_bit);
    wire logic [7:0] tbl_b0 = sfr_tbl(addr);
    wire logic [7:0] tbl_b1 = sfr_tbl(addr + 24'h000001);

    always_ff @(posedge sclk_i or posedge link_clr) begin
        if (link_clr) begin
            cnt <= 16'h0000;
            sh <= 8'h00;
            op <= `SFR_OP_NONE;
            addr <= 24'h000000;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sh <= next_sh;
            if (cnt == `SFR_OP_LAST) begin
                op <= ign_q ? `SFR_OP_NONE : next_sh;
            end
            if (cnt >= `SFR_ADDR_FIRST && cnt < `SFR_ADDR_END) begin
                addr <= {addr[22:0], si_i};
            end
            so_o <= next_so;
            so_oe_o <= next_oe;
        end
    end

    // Opcode handed over by toggle; op_hold stays put until the next opcode
    always_ff @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_tog <= 1'b0;
            op_hold <= 8'h00;
            ign_s <= 3'h0;
            ign_q <= 1'b0;
        end else begin
            ign_s <= {ign_s[1:0], ign_src};
            if (ign_s[1] == ign_s[2]) begin
                ign_q <= ign_s[2];
            end
            if (cnt == `SFR_OP_LAST) begin
                op_tog <= ~op_tog;
                op_hold <= next_sh;
            end
        end
    end

    // ----------------------------------------
    // Crossing into the system clock
    // ----------------------------------------
    logic [2:0] cs_s;
    logic [2:0] tog_s;
    logic cs_q;
    logic tog_q;
    wire logic cs_new = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_q;
    wire logic tog_new = (tog_s[1] == tog_s[2]) ? tog_s[2] : tog_q;
    wire logic cs_rise = cs_new & ~cs_q;
    wire logic cs_fall = ~cs_new & cs_q;
    wire logic op_ev = tog_new ^ tog_q;
    wire logic ev = op_ev | cs_rise;
    wire sfr_item_s new_item = '{has_op: op_ev, is_end: cs_rise, code: op_hold};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cs_s <= 3'h7;
            tog_s <= 3'h0;
            cs_q <= 1'b1;
            tog_q <= 1'b0;
        end else begin
            cs_s <= {cs_s[1:0], cs_n_i};
            tog_s <= {tog_s[1:0], op_tog};
            cs_q <= cs_new;
            tog_q <= tog_new;
        end
    end

    // ----------------------------------------
    // Capture stage and FIFO
    // ----------------------------------------
    sfr_item_s cap;
    logic cap_valid;
    logic in_ready;
    sfr_item_s item;
    logic f_valid;
    // Interpreter stalls while an abort waits, so the FIFO really fills
    logic f_ready;
    wire logic next_cap_valid = ev | (cap_valid & ~in_ready);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cap <= '0;
            cap_valid <= 1'b0;
            overrun_o <= 1'b0;
        end else begin
            cap_valid <= next_cap_valid;
            if (ev) begin
                cap <= new_item;
            end
            // Sticky; a lost event here means the host outran the stall
            overrun_o <= overrun_o | (ev & cap_valid & ~in_ready);
        end
    end

    sfr_fifo #(
        .W($bits(sfr_item_s)),
        .D(`SFR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_data_i(cap),
        .in_valid_i(cap_valid),
        .in_ready_o(in_ready),
        .out_data_o(item),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready)
    );

    // ----------------------------------------
    // Interpreter
    // ----------------------------------------
    sfr_state_e st;
    sfr_state_e next_st;
    logic armed;
    logic pend;
    logic [10:0] rec_cnt;

    assign f_ready = (st != SFR_ABORT);
    wire logic live = f_valid & f_ready & (st == SFR_IDLE);
    wire logic op_live = live & item.has_op;
    wire logic end_live = live & item.is_end;
    wire logic is_arm = (item.code == `SFR_OP_ARM);
    wire logic exec = op_live & (item.code == `SFR_OP_EXE) & armed;
    wire logic next_pend = (st != SFR_IDLE) ? 1'b0 : end_live ? 1'b0
        : op_live ? is_arm : pend;
    // Any opcode, null included, drops the arm; a full arm frame sets it
    wire logic next_armed = (st != SFR_IDLE) ? 1'b0
        : op_live ? (end_live & is_arm)
        : end_live ? pend : armed;
    wire logic enter_rec = (next_st == SFR_REC) && (st != SFR_REC);
    wire logic [10:0] next_rec = enter_rec ? REC_LAST
        : (rec_cnt != 11'h000) ? rec_cnt - 11'h001 : rec_cnt;
    wire logic next_standby = exec | (~cs_fall & (cs_rise | standby_o));

    always_comb begin
        next_st = st;
        case (st)
            SFR_IDLE: begin
                if (exec) begin
                    next_st = prog_busy_i ? SFR_ABORT : SFR_REC;
                end
            end
            SFR_ABORT: begin
                if (!prog_busy_i) begin
                    next_st = SFR_REC;
                end
            end
            SFR_REC: begin
                if (rec_cnt == 11'h000) begin
                    next_st = SFR_IDLE;
                end
            end
            default: next_st = SFR_IDLE;
        endcase
    end

    assign ign_src = busy_o;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st <= SFR_IDLE;
            armed <= 1'b0;
            pend <= 1'b0;
            rec_cnt <= 11'h000;
            soft_reset_o <= 1'b0;
            abort_o <= 1'b0;
            standby_o <= 1'b1;
            busy_o <= 1'b0;
        end else begin
            st <= next_st;
            armed <= next_armed;
            pend <= next_pend;
            rec_cnt <= next_rec;
            soft_reset_o <= exec;
            abort_o <= (next_st == SFR_ABORT);
            standby_o <= next_standby;
            busy_o <= (next_st != SFR_IDLE);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_reset_pulse;
        soft_reset_o ##1 !soft_reset_o;
    endsequence

    sequence s_rec_start;
        (st == SFR_REC || st == SFR_ABORT) && busy_o;
    endsequence

    a_exec_needs_arm: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        exec |-> armed && !$past(op_live))
        else $error("execute without completed arm");
    a_null_cancels: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_live && item.code == `SFR_OP_NULL) |=> !armed)
        else $error("null command left reset armed");
    a_other_cancels: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_live && !is_arm) |=> !armed ##1 !exec)
        else $error("arm survived another command");
    a_exec_standby: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        exec |=> standby_o and s_rec_start)
        else $error("execute did not enter standby");
    a_reset_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        exec |=> s_reset_pulse)
        else $error("software reset pulse wrong");
    a_abort_busy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (exec && prog_busy_i) |=> abort_o && !f_ready)
        else $error("busy operation not aborted");
    a_rec_ignores: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (st == SFR_REC && rec_cnt == REC_LAST) |-> busy_o [*8] ##1 !armed)
        else $error("command accepted during recovery");
    a_cs_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cs_n_i |-> !so_oe_o)
        else $error("output driven after deselect");
    a_uid_first: assert property (@(posedge sclk_i) disable iff (link_clr)
        (uid_act && cnt == 16'd39) |=> so_oe_o && so_o == UNIQUE_ID[127])
        else $error("identifier not started after dummies");
    a_tbl_start: assert property (@(posedge sclk_i) disable iff (link_clr)
        (tbl_act && cnt == 16'd39) |=> so_oe_o && so_o == $past(tbl_b0[7]))
        else $error("table data not started after dummy");
    a_tbl_advance: assert property (@(posedge sclk_i) disable iff (link_clr)
        (tbl_act && cnt == 16'd47) |=> so_o == $past(tbl_b1[7]))
        else $error("table address did not advance");
endmodule : sfr_core

`default_nettype wire

// file: sfr_consts.svh
/*
 * Constants of the reset, unique-ID and parameter-table command slice.
 * Assumes nothing; its guard makes repeated inclusion harmless.
 */
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define SFR_OP_NULL 8'h00
`define SFR_OP_ARM 8'h66
`define SFR_OP_EXE 8'h99
`define SFR_OP_UID 8'h4B
`define SFR_OP_TBL 8'h5A
`define SFR_OP_NONE 8'hFF

// ----------------------------------------
// Frame bit positions
// ----------------------------------------
`define SFR_OP_LAST 16'd7
`define SFR_ADDR_FIRST 16'd8
`define SFR_ADDR_END 16'd32
`define SFR_HDR_BITS 16'd40

// ----------------------------------------
// Parameter table contents
// ----------------------------------------
`define SFR_TBL_B0 8'h53
`define SFR_TBL_B1 8'h46
`define SFR_TBL_B2 8'h44
`define SFR_TBL_B3 8'h50
`define SFR_TBL_FILL 8'hFF

// ----------------------------------------
// Timing and buffering
// ----------------------------------------
`define SFR_CLK_NS 25
`define SFR_REC_NS 30000
`define SFR_REC_CYC ((`SFR_REC_NS + `SFR_CLK_NS - 1) / `SFR_CLK_NS)
`define SFR_FIFO_DEPTH 8

`endif

// file: sfr_pkg.sv
/*
 * Types of the reset, unique-ID and parameter-table command slice.
 * Assumes nothing of its surroundings.
 */
package sfr_pkg;
    // One captured link event: an opcode, a frame end, or both
    typedef struct packed {
        logic has_op;
        logic is_end;
        logic [7:0] code;
    } sfr_item_s;

    typedef enum logic [1:0] {
        SFR_IDLE,
        SFR_ABORT,
        SFR_REC
    } sfr_state_e;
endpackage : sfr_pkg

// file: sfr_host.sv
/*
 * Host serial controller model that faces the link of the command slice.
 * Assumes the bench calls xfer one frame at a time; sclk idles low outside frames.
 */
`timescale 1ns/10ps
`default_nettype none
module sfr_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    initial begin
        sclk_o = 1'b0;
        si_o = 1'b0;
        // Late deselect, so the link reset sees a real edge
        #1 cs_n_o = 1'b1;
    end

    // -------------------------------------
    // One frame: nhd header bits, then nrd bits read back
    // -------------------------------------
    task automatic xfer(input logic [39:0] hdr, input int nhd, input int nrd,
                        output logic [127:0] rd, output logic oe);
        rd = '0;
        oe = 1'b0;
        cs_n_o = 1'b0;
        #7.5;
        for (int i = nhd - 1; i >= 0; i--) begin
            si_o = hdr[i];
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
        for (int i = 0; i < nrd; i++) begin
            // Line is a don't care here, so keep it moving
            si_o = ~si_o;
            #7.5;
            rd = {rd[126:0], so_i};
            oe = so_oe_i;
            sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
        #7.5 cs_n_o = 1'b1;
        si_o = ~si_o;
        // Gap well above the 100 ns the crossings need
        #300;
    endtask : xfer
endmodule : sfr_host
`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench of the command slice: reads, reset sequences, abort, overrun.
 * Assumes sfr_core and the sfr_host partner model in the same compile.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sfr_pkg::*;
    // Arbitrary identifier for this bench
    localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF;
    typedef struct {
        logic [39:0] hdr;
        int nrd;
        logic [127:0] exp;
        logic oe;
    } sfr_row_s;
    logic clk, reset_n, sclk, cs_n, si, so, so_oe, prog_busy;
    logic soft_reset, abort, standby, busy, overrun;
    logic [127:0] rd;
    logic oe;
    int errors = 0;
    int checked = 0;
    sfr_row_s rows [4] = '{
        '{40'h4B00000000, 128, UID, 1'b1},
        '{40'h5A00000000, 32, 128'h53464450, 1'b1},
        '{40'h5A00000300, 16, 128'h50FF, 1'b1},
        '{40'h0000000000, 8, 128'h0, 1'b0}
    };

    sfr_core #(.UNIQUE_ID(UID)) i_sfr_core (.clk_i(clk), .reset_n_i(reset_n), .sclk_i(sclk),
        .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .prog_busy_i(prog_busy),
        .soft_reset_o(soft_reset), .abort_o(abort), .standby_o(standby), .busy_o(busy),
        .overrun_o(overrun));
    sfr_host i_sfr_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

    // -------------------------------------
    // Helpers
    // -------------------------------------
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic frame(input logic [39:0] hdr, input int nhd, input int nrd);
        i_sfr_host.xfer(hdr, nhd, nrd, rd, oe);
    endtask : frame

    task automatic wait_sig(input int lim, input logic lvl, ref logic s);
        for (int k = 0; k < lim && s !== lvl; k++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_sig

    // Pulse must come within 40 clock cycles of the frame start
    task automatic exe_try(input logic [39:0] hdr, input int nhd, input logic exp);
        logic seen;
        fork
            frame(hdr, nhd, 0);
            begin
                wait_sig(40, 1'b1, soft_reset);
                // Pulse lasts one cycle, so keep what was seen
                seen = soft_reset;
            end
        join
        chk(seen, exp);
    endtask : exe_try

    task automatic print_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // -------------------------------------
    // Clock, watchdog, main sequence
    // -------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #400000;
        errors++;
        print_verdict();
    end

    initial begin
        // Edge after time zero, so the asynchronous link resets see it
        reset_n = 1'b1;
        prog_busy = 1'b0;
        #2 reset_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        chk({standby, busy, so_oe, overrun, abort}, 5'h10);
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            frame(rows[i].hdr, 40, rows[i].nrd);
            chk(oe, rows[i].oe);
            if (rows[i].oe) chk(rd, rows[i].exp);
            chk(so_oe, 1'b0);
        end
        exe_try(40'h99, 8, 1'b0);
        frame(40'h66, 8, 0);
        frame(40'h00, 8, 0);
        exe_try(40'h99, 8, 1'b0);
        frame(40'h66, 8, 0);
        frame(40'h4B, 8, 0);
        exe_try(40'h99, 8, 1'b0);
        exe_try(40'h6699, 16, 1'b0);
        // Trailing byte is not decoded, so that frame armed; cancel it
        frame(40'h00, 8, 0);
        exe_try(40'h99, 8, 1'b0);
        frame(40'h66, 8, 0);
        exe_try(40'h99, 8, 1'b1);
        chk({standby, busy, abort}, 3'h6);
        frame(40'h4B00000000, 40, 8);
        chk(oe, 1'b0);
        wait_sig(1300, 1'b0, busy);
        chk(busy, 1'b0);
        // Reset during a program: FIFO stalls in the abort wait, so flood it
        @(posedge clk);
        #1 prog_busy = 1'b1;
        frame(40'h66, 8, 0);
        exe_try(40'h99, 8, 1'b1);
        for (int i = 0; i < 10; i++) frame(40'h00, 8, 0);
        chk({abort, busy, overrun}, 3'h7);
        @(posedge clk);
        #1 prog_busy = 1'b0;
        wait_sig(10, 1'b0, abort);
        chk(abort, 1'b0);
        wait_sig(1300, 1'b0, busy);
        chk(busy, 1'b0);
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        chk({standby, overrun, so_oe}, 3'h4);
        repeat (4) @(posedge clk);
        frame(40'h4B00000000, 40, 128);
        chk(rd, UID);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
